// >>> rtl/cpco_consts.svh
`ifndef CPCO_CONSTS_SVH
`define CPCO_CONSTS_SVH

// ----------------------------------------------------------------
// option register layout
// ----------------------------------------------------------------
`define CPCO_OPT_RESET 8'h00
`define CPCO_OPT_MC_HI 1
`define CPCO_OPT_MC_LO 0
`define CPCO_OPT_BCD2 4
`define CPCO_OPT_BCDF 5
`define CPCO_OPT_ICLD 6
`define CPCO_OPT_AUX 7

// ----------------------------------------------------------------
// serial exchange operand and timing
// ----------------------------------------------------------------
`define CPCO_SER_CONT 7
`define CPCO_SER_SEL_HI 2
`define CPCO_SER_LAST 3'h7
`define CPCO_SER_CNT_ZERO 3'h0
`define CPCO_SER_CNT_ONE 3'h1
`define CPCO_SEL_NONE_N 3'h7
`define CPCO_BYTE_ZERO 8'h00

`endif

// >>> rtl/cpco_pkg.sv
package cpco_pkg;

  typedef enum logic [1:0]
  {
    MC_NMOS = 2'h0,
    MC_CMOS = 2'h1,
    MC_NMOS_NOP = 2'h2,
    MC_EXT = 2'h3
  } cpco_mcode_t;

  typedef enum logic [3:0]
  {
    SER_IDLE = 4'h1,
    SER_LEAD = 4'h2,
    SER_SHIFT = 4'h4,
    SER_TAIL = 4'h8
  } cpco_ser_state_t;

endpackage

// >>> rtl/cpco_ser_if.sv
`timescale 1ns/1ps
interface cpco_ser_if;
  logic req_tgl;
  logic [7:0] tx;
  logic [2:0] sel;
  logic cont;
  logic ack_tgl;
  logic [7:0] rx;

  modport core
  (
    output req_tgl, tx, sel, cont,
    input ack_tgl, rx
  );

  modport link
  (
    input req_tgl, tx, sel, cont,
    output ack_tgl, rx
  );
endinterface

// >>> rtl/cpco_serial.sv
`timescale 1ns/1ps
`include "cpco_consts.svh"

module cpco_serial
(
  input wire logic link_clk, // phase two clock
  input wire logic rst, // core domain reset, synchronised here
  cpco_ser_if.link ser, // request and result from the core domain
  input wire logic miso, // serial data in
  output logic sclk, // serial clock, idle high
  output logic mosi, // serial data out
  output logic [2:0] sel_n // peripheral selects, active low
);
  logic rst_meta_ff, rst_ff, req_meta_ff, req_sync_ff, req_seen_ff;
  logic en_ff, cont_ff, ack_ff, mosi_ff;
  logic [2:0] cnt_ff, sel_n_ff;
  logic [7:0] tx_ff, rx_ff;
  logic start;
  cpco_pkg::cpco_ser_state_t state_ff;

  // ----------------------------------------------------------------
  // crossings
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk)
  begin
    rst_meta_ff <= rst;
    rst_ff <= rst_meta_ff;
    req_meta_ff <= ser.req_tgl;
    req_sync_ff <= req_meta_ff;
  end

  assign start = (state_ff == cpco_pkg::SER_IDLE) && (req_sync_ff != req_seen_ff);

  // ----------------------------------------------------------------
  // sequence: one lead cycle, eight bit cycles, one tail cycle
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk)
  begin
    if (rst_ff)
      state_ff <= cpco_pkg::SER_IDLE;
    else
      unique case (state_ff)
        cpco_pkg::SER_IDLE: if (start) state_ff <= cpco_pkg::SER_LEAD;
        cpco_pkg::SER_LEAD: state_ff <= cpco_pkg::SER_SHIFT;
        cpco_pkg::SER_SHIFT: if (cnt_ff == `CPCO_SER_LAST) state_ff <= cpco_pkg::SER_TAIL; // RL15
        cpco_pkg::SER_TAIL: state_ff <= cpco_pkg::SER_IDLE;
        default: state_ff <= cpco_pkg::SER_IDLE;
      endcase
  end

  always_ff @(posedge link_clk)
  begin
    if (rst_ff)
    begin
      req_seen_ff <= 1'b0;
      tx_ff <= `CPCO_BYTE_ZERO;
      cont_ff <= 1'b0;
    end
    else if (start)
    begin
      req_seen_ff <= req_sync_ff;
      tx_ff <= ser.tx;
      cont_ff <= ser.cont;
    end
  end

  always_ff @(posedge link_clk)
  begin
    if (rst_ff)
      sel_n_ff <= `CPCO_SEL_NONE_N; // RL20
    else if (start)
      sel_n_ff <= ~ser.sel; // RL13 RL16
    else if (state_ff == cpco_pkg::SER_TAIL && !cont_ff)
      sel_n_ff <= `CPCO_SEL_NONE_N; // RL16
  end

  always_ff @(posedge link_clk)
  begin
    if (rst_ff)
    begin
      en_ff <= 1'b0;
      cnt_ff <= `CPCO_SER_CNT_ZERO;
    end
    else
    begin
      en_ff <= (state_ff == cpco_pkg::SER_LEAD) ||
               (state_ff == cpco_pkg::SER_SHIFT && cnt_ff != `CPCO_SER_LAST); // RL14
      if (state_ff == cpco_pkg::SER_SHIFT)
        cnt_ff <= cnt_ff + `CPCO_SER_CNT_ONE;
      else
        cnt_ff <= `CPCO_SER_CNT_ZERO;
    end
  end

  // mode 3: data moves on the falling edge, is sampled on the rising edge
  always_ff @(negedge link_clk)
  begin
    if (rst_ff)
      mosi_ff <= 1'b1;
    else if (en_ff)
      mosi_ff <= tx_ff[`CPCO_SER_LAST - cnt_ff]; // RL12 RL15
  end

  always_ff @(posedge link_clk)
  begin
    if (rst_ff)
    begin
      rx_ff <= `CPCO_BYTE_ZERO;
      ack_ff <= 1'b0;
    end
    else
    begin
      if (state_ff == cpco_pkg::SER_SHIFT)
        rx_ff <= {rx_ff[6:0], miso}; // RL12
      if (state_ff == cpco_pkg::SER_TAIL)
        ack_ff <= ~ack_ff;
    end
  end

  // en_ff only changes while the clock is high, so the gated clock cannot glitch
  assign sclk = ~en_ff | link_clk; // RL12 RL14
  assign mosi = mosi_ff;
  assign sel_n = sel_n_ff;
  assign ser.ack_tgl = ack_ff;
  assign ser.rx = rx_ff;
endmodule

// >>> rtl/cpco_top.sv
`timescale 1ns/1ps
`include "cpco_consts.svh"

// Notes on behaviour
// RL1 - ready low stalls reads and writes
// RL2 - device pulls ready low during wait
// RL3 - float inputs release buses without clock
// RL4 - memory lock only in cmos, extended microcode
// RL5 - vector pull needs its strap closed
// RL6 - both headers carry identical signals together
// RL7 - extended mode low under extended microcode
// RL8 - high bank low for nonzero bank under extended microcode
// RL9 - io port enabled while high bank high
// RL10 - aux output follows option bit seven
// RL11 - aux low when option register disabled
// RL12 - serial master, mode three timing
// RL13 - three software controlled peripheral selects
// RL14 - one serial clock toggle per cycle
// RL15 - eight bits msb first, ten cycles
// RL16 - operand picks selects, continue keeps them
// RL17 - option register swaps with accumulator only
// RL18 - option bits one-zero pick the microcode
// RL19 - aux changes cleanly by instruction end
// RL20 - selects inactive after reset and idle
module cpco_top #(
  parameter int ADDR_W = 16,
  parameter int BANK_W = 8
)
(
  input wire logic CLK, // core clock
  input wire logic RST, // synchronous reset, active high
  input wire logic PHASE_TWO_CLOCK, // processor cycle clock for the serial port
  input wire logic [ADDR_W-1:0] CORE_ADDR, // address of the current cycle
  input wire logic [BANK_W-1:0] CORE_BANK, // bank of the current cycle
  input wire logic CORE_BANK_VALID, // current cycle uses a bank
  input wire logic [7:0] CORE_WDATA, // write data
  input wire logic CORE_WRITE, // current cycle is a write
  input wire logic CORE_LOCK, // read-modify-write in progress
  input wire logic CORE_VECTOR, // vector fetch in progress
  input wire logic CORE_WAIT_OP, // wait for interrupt executing
  output logic [7:0] CORE_RDATA, // read data from the bus
  output logic CORE_STALL, // ready pin low, hold the cycle
  input wire logic OPT_XCHG, // exchange accumulator with option register
  input wire logic [7:0] ACC_WDATA, // accumulator value for the exchange
  output logic [7:0] OPT_RDATA, // value returned to the accumulator
  output logic [1:0] MCODE_SEL, // active microcode
  output logic OPT_TWO_CYCLE_BCD, // two cycle decimal option
  output logic OPT_BCD_FLAGS_VALID, // decimal flags valid option
  output logic OPT_IRQ_CLD, // clear decimal on interrupt option
  input wire logic SER_START, // serial exchange request pulse
  input wire logic [7:0] SER_OPERAND, // selects and continue
  input wire logic [7:0] SER_TXDATA, // accumulator to send
  output logic SER_BUSY, // exchange in flight
  output logic SER_DONE, // exchange finished pulse
  output logic [7:0] SER_RXDATA, // byte received
  input wire logic OPT_ENABLE_STRAP, // option register enabled when high
  input wire logic [1:0] MCODE_STRAP, // microcode when option register disabled
  input wire logic VECTOR_PULL_STRAP, // closed (high) enables vector pull
  input wire logic IO_PORT_STRAP, // on-board io port fitted
  input wire logic BUS_FLOAT_CONTROL, // low floats the buses
  input wire logic BUS_FLOAT_CONTROL_ALT, // low floats the buses, second header
  input wire logic READY_IN, // ready pin level
  output logic READY_OUT, // ready pin drive value
  output logic READY_OE, // ready pin driven
  input wire logic [7:0] DATA_IN, // data bus level
  output logic [ADDR_W-1:0] HDR_A_ADDR, // address, first header
  output logic [ADDR_W-1:0] HDR_B_ADDR, // address, second header
  output logic HDR_A_ADDR_OE, // address drive, first header
  output logic HDR_B_ADDR_OE, // address drive, second header
  output logic [7:0] HDR_A_DATA_OUT, // data out, first header
  output logic [7:0] HDR_B_DATA_OUT, // data out, second header
  output logic HDR_A_DATA_OE, // data drive, first header
  output logic HDR_B_DATA_OE, // data drive, second header
  output logic HDR_A_RW, // read high, write low, first header
  output logic HDR_B_RW, // read high, write low, second header
  output logic HDR_A_RW_OE, // rw drive, first header
  output logic HDR_B_RW_OE, // rw drive, second header
  output logic HDR_A_MEMORY_LOCK_OUT_N, // memory lock, first header
  output logic HDR_B_MEMORY_LOCK_OUT_N, // memory lock, second header
  output logic HDR_A_VECTOR_PULL_OUT_N, // vector pull, first header
  output logic HDR_B_VECTOR_PULL_OUT_N, // vector pull, second header
  output logic EXTENDED_MODE_N, // extended microcode active
  output logic HIGH_BANK_ACCESS_N, // access outside bank zero
  output logic [BANK_W-1:0] EXT_BANK_OUT, // bank of the current cycle
  output logic IO_PORT_EN, // on-board io port decode enable
  output logic USER_AUX_OUT, // user auxiliary output
  output logic SER_SCLK, // serial clock
  output logic SER_MOSI, // serial data out
  input wire logic SER_MISO, // serial data in
  output logic PERIPH_SELECT_ZERO_N, // peripheral select 0
  output logic PERIPH_SELECT_ONE_N, // peripheral select 1
  output logic PERIPH_SELECT_TWO_N // peripheral select 2
);

  // ----------------------------------------------------------------
  // pin and strap synchronisers
  // ----------------------------------------------------------------
  logic rdy_meta_ff, rdy_ff, opt_en_meta_ff, opt_en_ff;
  logic vp_strap_meta_ff, vp_strap_ff, io_strap_meta_ff, io_strap_ff;
  logic [1:0] mc_strap_meta_ff, mc_strap_ff;
  logic [7:0] din_meta_ff, din_ff;

  always_ff @(posedge CLK)
  begin
    rdy_meta_ff <= READY_IN;
    rdy_ff <= rdy_meta_ff;
    opt_en_meta_ff <= OPT_ENABLE_STRAP;
    opt_en_ff <= opt_en_meta_ff;
    vp_strap_meta_ff <= VECTOR_PULL_STRAP;
    vp_strap_ff <= vp_strap_meta_ff;
    io_strap_meta_ff <= IO_PORT_STRAP;
    io_strap_ff <= io_strap_meta_ff;
    mc_strap_meta_ff <= MCODE_STRAP;
    mc_strap_ff <= mc_strap_meta_ff;
    din_meta_ff <= DATA_IN;
    din_ff <= din_meta_ff;
  end

  // ----------------------------------------------------------------
  // ready pause and wait drive
  // ----------------------------------------------------------------
  logic rdy_drive_ff;

  // the pin is read back, so a direct external high defeats the wait pause
  assign CORE_STALL = ~rdy_ff; // RL1 RL2
  assign CORE_RDATA = din_ff;

  always_ff @(posedge CLK)
  begin
    if (RST)
      rdy_drive_ff <= 1'b0;
    else
      rdy_drive_ff <= CORE_WAIT_OP; // RL2
  end

  assign READY_OUT = 1'b0;
  assign READY_OE = rdy_drive_ff; // RL2

  // ----------------------------------------------------------------
  // option register
  // ----------------------------------------------------------------
  logic [7:0] opt_ff, opt_rdata_ff;

  // a disabled register leaves the accumulator unchanged
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      opt_ff <= `CPCO_OPT_RESET;
      opt_rdata_ff <= `CPCO_BYTE_ZERO;
    end
    else if (OPT_XCHG)
    begin
      if (opt_en_ff)
      begin
        opt_ff <= ACC_WDATA; // RL17
        opt_rdata_ff <= opt_ff; // RL17
      end
      else
        opt_rdata_ff <= ACC_WDATA;
    end
  end

  assign OPT_RDATA = opt_rdata_ff;

  // ----------------------------------------------------------------
  // microcode selection and its options
  // ----------------------------------------------------------------
  cpco_pkg::cpco_mcode_t mc;
  logic mc_cmos_like;
  logic [1:0] mc_ff;
  logic bcd2_ff, bcdf_ff, icld_ff, aux_ff;

  assign mc = cpco_pkg::cpco_mcode_t'(opt_en_ff ?
              opt_ff[`CPCO_OPT_MC_HI:`CPCO_OPT_MC_LO] : mc_strap_ff); // RL18
  assign mc_cmos_like = (mc == cpco_pkg::MC_CMOS) || (mc == cpco_pkg::MC_EXT);

  // without the register the options follow the chosen instruction set
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      mc_ff <= cpco_pkg::MC_NMOS;
      bcd2_ff <= 1'b0;
      bcdf_ff <= 1'b0;
      icld_ff <= 1'b0;
    end
    else
    begin
      mc_ff <= mc; // RL18
      bcd2_ff <= opt_en_ff ? opt_ff[`CPCO_OPT_BCD2] : mc_cmos_like;
      bcdf_ff <= opt_en_ff ? opt_ff[`CPCO_OPT_BCDF] : mc_cmos_like;
      icld_ff <= opt_en_ff ? opt_ff[`CPCO_OPT_ICLD] : mc_cmos_like;
    end
  end

  // output straight from a flop so a change never glitches
  always_ff @(posedge CLK)
  begin
    if (RST)
      aux_ff <= 1'b0;
    else
      aux_ff <= opt_en_ff & opt_ff[`CPCO_OPT_AUX]; // RL10 RL11 RL19
  end

  assign MCODE_SEL = mc_ff;
  assign OPT_TWO_CYCLE_BCD = bcd2_ff;
  assign OPT_BCD_FLAGS_VALID = bcdf_ff;
  assign OPT_IRQ_CLD = icld_ff;
  assign USER_AUX_OUT = aux_ff;

  // ----------------------------------------------------------------
  // bus pins and status outputs
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] addr_ff;
  logic [BANK_W-1:0] bank_ff;
  logic [7:0] wdata_ff;
  logic write_ff, lock_n_ff, vp_n_ff, ext_n_ff, hbank_n_ff, io_en_ff, bus_on;
  logic high_bank;

  assign high_bank = CORE_BANK_VALID && (CORE_BANK != BANK_W'(`CPCO_BYTE_ZERO));

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      addr_ff <= '0;
      bank_ff <= '0;
      wdata_ff <= `CPCO_BYTE_ZERO;
      write_ff <= 1'b0;
    end
    else
    begin
      addr_ff <= CORE_ADDR;
      bank_ff <= CORE_BANK;
      wdata_ff <= CORE_WDATA;
      write_ff <= CORE_WRITE;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      lock_n_ff <= 1'b1;
      vp_n_ff <= 1'b1;
      ext_n_ff <= 1'b1;
      hbank_n_ff <= 1'b1;
      io_en_ff <= 1'b0;
    end
    else
    begin
      lock_n_ff <= ~(CORE_LOCK & mc_cmos_like); // RL4
      vp_n_ff <= ~(CORE_VECTOR & vp_strap_ff); // RL5
      ext_n_ff <= ~(mc == cpco_pkg::MC_EXT); // RL7
      hbank_n_ff <= ~((mc == cpco_pkg::MC_EXT) & high_bank); // RL8
      io_en_ff <= io_strap_ff & ~((mc == cpco_pkg::MC_EXT) & high_bank); // RL9
    end
  end

  // float acts on the pins directly, no clock in the path
  assign bus_on = BUS_FLOAT_CONTROL & BUS_FLOAT_CONTROL_ALT; // RL3

  // both headers fan out from the same flops and the same float gate
  assign HDR_A_ADDR = addr_ff; // RL6
  assign HDR_B_ADDR = addr_ff; // RL6
  assign HDR_A_ADDR_OE = bus_on; // RL3 RL6
  assign HDR_B_ADDR_OE = bus_on; // RL3 RL6
  assign HDR_A_DATA_OUT = wdata_ff; // RL6
  assign HDR_B_DATA_OUT = wdata_ff; // RL6
  assign HDR_A_DATA_OE = bus_on & write_ff; // RL3
  assign HDR_B_DATA_OE = bus_on & write_ff; // RL3
  assign HDR_A_RW = ~write_ff;
  assign HDR_B_RW = ~write_ff;
  assign HDR_A_RW_OE = bus_on; // RL3
  assign HDR_B_RW_OE = bus_on; // RL3
  assign HDR_A_MEMORY_LOCK_OUT_N = lock_n_ff; // RL6
  assign HDR_B_MEMORY_LOCK_OUT_N = lock_n_ff; // RL6
  assign HDR_A_VECTOR_PULL_OUT_N = vp_n_ff; // RL6
  assign HDR_B_VECTOR_PULL_OUT_N = vp_n_ff; // RL6
  assign EXTENDED_MODE_N = ext_n_ff;
  assign HIGH_BANK_ACCESS_N = hbank_n_ff;
  assign EXT_BANK_OUT = bank_ff;
  assign IO_PORT_EN = io_en_ff;

  // ----------------------------------------------------------------
  // serial exchange, core side of the crossing
  // ----------------------------------------------------------------
  cpco_ser_if ser_if ();
  logic req_tgl_ff, busy_ff, cont_ff, done_ff;
  logic ack_meta_ff, ack_sync_ff, ack_seen_ff, ack_evt;
  logic [2:0] sel_ff;
  logic [7:0] tx_ff, rx_ff;
  logic [2:0] sel_n;

  // request fields stay still while busy so the link side reads them safely
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      req_tgl_ff <= 1'b0;
      tx_ff <= `CPCO_BYTE_ZERO;
      sel_ff <= 3'h0;
      cont_ff <= 1'b0;
    end
    else if (SER_START && !busy_ff)
    begin
      req_tgl_ff <= ~req_tgl_ff;
      tx_ff <= SER_TXDATA; // RL15
      sel_ff <= SER_OPERAND[`CPCO_SER_SEL_HI:0]; // RL16
      cont_ff <= SER_OPERAND[`CPCO_SER_CONT]; // RL16
    end
  end

  always_ff @(posedge CLK)
  begin
    ack_meta_ff <= ser_if.ack_tgl;
    ack_sync_ff <= ack_meta_ff;
  end

  assign ack_evt = ack_sync_ff != ack_seen_ff;

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ack_seen_ff <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      rx_ff <= `CPCO_BYTE_ZERO;
    end
    else
    begin
      ack_seen_ff <= ack_sync_ff;
      done_ff <= ack_evt & busy_ff;
      if (SER_START && !busy_ff)
        busy_ff <= 1'b1;
      else if (ack_evt)
        busy_ff <= 1'b0;
      if (ack_evt)
        rx_ff <= ser_if.rx; // RL15
    end
  end

  assign ser_if.req_tgl = req_tgl_ff;
  assign ser_if.tx = tx_ff;
  assign ser_if.sel = sel_ff;
  assign ser_if.cont = cont_ff;

  cpco_serial u_serial
  (
    .link_clk(PHASE_TWO_CLOCK),
    .rst(RST),
    .ser(ser_if.link),
    .miso(SER_MISO),
    .sclk(SER_SCLK),
    .mosi(SER_MOSI),
    .sel_n(sel_n)
  );

  assign SER_BUSY = busy_ff;
  assign SER_DONE = done_ff;
  assign SER_RXDATA = rx_ff;
  assign PERIPH_SELECT_ZERO_N = sel_n[0]; // RL13
  assign PERIPH_SELECT_ONE_N = sel_n[1]; // RL13
  assign PERIPH_SELECT_TWO_N = sel_n[2]; // RL13
endmodule

// >>> bench/cpco_asserts.sv
`timescale 1ns/1ps
module cpco_asserts #(
  parameter int ADDR_W = 16
)
(
  input wire logic CLK, // core clock
  input wire logic RST, // sync reset
  input wire logic READY_IN, CORE_STALL, CORE_WAIT_OP, READY_OE, READY_OUT, // ready pin
  input wire logic BUS_FLOAT_CONTROL, BUS_FLOAT_CONTROL_ALT, // float pins
  input wire logic HDR_A_ADDR_OE, HDR_B_ADDR_OE, HDR_A_DATA_OE, HDR_B_DATA_OE, // drives
  input wire logic HDR_A_RW, HDR_B_RW, HDR_A_RW_OE, HDR_B_RW_OE, // rw pins
  input wire logic [ADDR_W-1:0] HDR_A_ADDR, HDR_B_ADDR, // address pins
  input wire logic [7:0] HDR_A_DATA_OUT, HDR_B_DATA_OUT, ACC_WDATA, // data
  input wire logic HDR_A_MEMORY_LOCK_OUT_N, HDR_B_MEMORY_LOCK_OUT_N, // lock
  input wire logic HDR_A_VECTOR_PULL_OUT_N, HDR_B_VECTOR_PULL_OUT_N, VECTOR_PULL_STRAP, // vp
  input wire logic [1:0] MCODE_SEL, // microcode
  input wire logic EXTENDED_MODE_N, HIGH_BANK_ACCESS_N, IO_PORT_EN, // decode
  input wire logic OPT_ENABLE_STRAP, OPT_XCHG, USER_AUX_OUT, // option
  input wire logic SER_START, SER_BUSY, SER_DONE, SER_SCLK, // serial
  input wire logic PERIPH_SELECT_ZERO_N, PERIPH_SELECT_ONE_N, PERIPH_SELECT_TWO_N // selects
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (RST);

  chk_stall_on_ready: assert property ((!READY_IN) [*3] |-> CORE_STALL)
    else $error("stall missing while ready low");
  chk_wait_pulls_ready: assert property (CORE_WAIT_OP [*2] |-> READY_OE && !READY_OUT)
    else $error("ready not pulled low during wait");
  chk_float_releases: assert property (!(BUS_FLOAT_CONTROL && BUS_FLOAT_CONTROL_ALT)
    |-> !(HDR_A_ADDR_OE || HDR_A_DATA_OE || HDR_A_RW_OE))
    else $error("bus driven while float requested");
  chk_headers_match: assert property (HDR_A_ADDR == HDR_B_ADDR
    && HDR_A_DATA_OUT == HDR_B_DATA_OUT && HDR_A_RW == HDR_B_RW
    && HDR_A_ADDR_OE == HDR_B_ADDR_OE && HDR_A_DATA_OE == HDR_B_DATA_OE
    && HDR_A_RW_OE == HDR_B_RW_OE && HDR_A_MEMORY_LOCK_OUT_N == HDR_B_MEMORY_LOCK_OUT_N
    && HDR_A_VECTOR_PULL_OUT_N == HDR_B_VECTOR_PULL_OUT_N)
    else $error("headers differ");
  chk_lock_mcode: assert property (!HDR_A_MEMORY_LOCK_OUT_N |-> MCODE_SEL[0]
    || $past(MCODE_SEL[0]))
    else $error("memory lock under wrong microcode");
  chk_vp_strap_open: assert property ((!VECTOR_PULL_STRAP) [*4]
    |-> HDR_A_VECTOR_PULL_OUT_N)
    else $error("vector pull with strap open");
  chk_ext_mode_low: assert property ((MCODE_SEL == 2'h3) [*2] |-> !EXTENDED_MODE_N)
    else $error("extended mode not flagged");
  chk_io_high_bank: assert property (IO_PORT_EN |-> HIGH_BANK_ACCESS_N
    || $past(HIGH_BANK_ACCESS_N))
    else $error("io port enabled on high bank");
  chk_aux_follows: assert property (OPT_ENABLE_STRAP [*3] ##0 OPT_XCHG
    |-> ##2 (USER_AUX_OUT == $past(ACC_WDATA[7], 2)))
    else $error("aux does not follow option bit");
  chk_aux_disabled: assert property ((!OPT_ENABLE_STRAP) [*4] |-> !USER_AUX_OUT)
    else $error("aux high with option register off");
  chk_sclk_idle: assert property (!SER_BUSY && !$past(SER_BUSY) |-> SER_SCLK)
    else $error("serial clock not idle high");
  chk_serial_len: assert property (SER_START && !SER_BUSY
    |-> ##[88:136] SER_DONE)
    else $error("serial exchange length wrong");
  chk_done_pulse: assert property (SER_DONE |=> !SER_DONE && !SER_BUSY)
    else $error("done not a single pulse");
  chk_sel_reset: assert property ($fell(RST) |-> PERIPH_SELECT_ZERO_N
    && PERIPH_SELECT_ONE_N && PERIPH_SELECT_TWO_N && !USER_AUX_OUT)
    else $error("selects or aux active after reset");
endmodule

// >>> bench/cpco_spi_periph.sv
`timescale 1ns/1ps
module cpco_spi_periph
(
  input wire logic sclk, // serial clock
  input wire logic mosi, // data from master
  input wire logic [2:0] sel_n, // selects, active low
  input wire logic [7:0] reply, // byte to return
  output logic miso, // data to master
  output logic [7:0] rx // byte received
);
  logic [7:0] sr = 8'h00;
  logic [2:0] cnt = 3'h0;
  logic d = 1'b0;
  logic desel;

  assign desel = &sel_n;

  // mode 3: change on falling edge, capture on rising edge
  always @(negedge sclk)
  begin
    d <= (cnt == 3'h0) ? reply[7] : sr[7];
    sr <= (cnt == 3'h0) ? {reply[6:0], 1'b0} : {sr[6:0], 1'b0};
  end

  // bit count restarts while nothing is selected, so clock edges seen during reset are forgotten
  always @(posedge sclk or posedge desel)
  begin
    if (desel)
      cnt <= 3'h0;
    else
    begin
      rx <= {rx[6:0], mosi};
      cnt <= cnt + 3'h1;
    end
  end

  // unselected: inverse of last bit so a stale value never passes
  assign miso = (&sel_n) ? ~d : d;
endmodule

// >>> bench/cpco_top_tb.sv
`timescale 1ns/1ps
module cpco_top_tb;
  logic CLK, RST, PHASE_TWO_CLOCK, CORE_BANK_VALID, CORE_WRITE, CORE_LOCK, CORE_VECTOR;
  logic CORE_WAIT_OP, OPT_XCHG, SER_START, OPT_ENABLE_STRAP, VECTOR_PULL_STRAP, IO_PORT_STRAP;
  logic BUS_FLOAT_CONTROL, BUS_FLOAT_CONTROL_ALT, READY_IN, SER_MISO;
  logic [15:0] CORE_ADDR, HDR_A_ADDR, HDR_B_ADDR;
  logic [7:0] CORE_BANK, CORE_WDATA, CORE_RDATA, ACC_WDATA, OPT_RDATA, SER_OPERAND, SER_TXDATA;
  logic [7:0] SER_RXDATA, DATA_IN, HDR_A_DATA_OUT, HDR_B_DATA_OUT, EXT_BANK_OUT, reply, rx_got;
  logic [1:0] MCODE_SEL, MCODE_STRAP;
  logic CORE_STALL, OPT_TWO_CYCLE_BCD, OPT_BCD_FLAGS_VALID, OPT_IRQ_CLD, SER_BUSY, SER_DONE;
  logic READY_OUT, READY_OE, HDR_A_ADDR_OE, HDR_B_ADDR_OE, HDR_A_DATA_OE, HDR_B_DATA_OE;
  logic HDR_A_RW, HDR_B_RW, HDR_A_RW_OE, HDR_B_RW_OE, HDR_A_MEMORY_LOCK_OUT_N;
  logic HDR_B_MEMORY_LOCK_OUT_N, HDR_A_VECTOR_PULL_OUT_N, HDR_B_VECTOR_PULL_OUT_N;
  logic EXTENDED_MODE_N, HIGH_BANK_ACCESS_N, IO_PORT_EN, USER_AUX_OUT, SER_SCLK, SER_MOSI;
  logic PERIPH_SELECT_ZERO_N, PERIPH_SELECT_ONE_N, PERIPH_SELECT_TWO_N;
  logic [2:0] seln;
  logic [7:0] old;
  logic ready_ext;
  int fails = 0;
  int comparisons = 0;

  assign seln = {PERIPH_SELECT_TWO_N, PERIPH_SELECT_ONE_N, PERIPH_SELECT_ZERO_N};
  // ready pin with a pull-up behind a diode: the design's low drive wins
  assign READY_IN = READY_OE ? READY_OUT : ready_ext;

  cpco_top i_cpco_top (.*);
  cpco_spi_periph i_cpco_spi_periph (.sclk(SER_SCLK), .mosi(SER_MOSI), .sel_n(seln),
    .reply(reply), .miso(SER_MISO), .rx(rx_got));

  initial
  begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  // link clock free running, eight core periods long, edges a fixed 3 ns after core clock edges
  initial
  begin
    PHASE_TWO_CLOCK = 1'b0;
    #3;
    forever #32 PHASE_TWO_CLOCK = ~PHASE_TWO_CLOCK;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic xchg(input logic [7:0] v, input logic [7:0] exp_old);
    @(negedge CLK);
    OPT_XCHG = 1'b1;
    ACC_WDATA = v;
    @(negedge CLK);
    OPT_XCHG = 1'b0;
    chk(OPT_RDATA, exp_old);
    repeat (3) @(negedge CLK);
  endtask

  task automatic spi(input logic [7:0] op, input logic [7:0] d, input logic [7:0] back);
    int n;
    @(negedge CLK);
    SER_START = 1'b1;
    SER_OPERAND = op;
    SER_TXDATA = d;
    reply = back;
    @(negedge CLK);
    SER_START = 1'b0;
    n = 0;
    while (SER_DONE !== 1'b1 && n < 400)
    begin
      @(negedge CLK);
      n++;
      if (n == 60)
        chk(seln, {~op[2:0]});
    end
    chk(SER_DONE, 8'h01);
    chk(SER_RXDATA, back);
    chk(rx_got, d);
    chk(seln, op[7] ? {~op[2:0]} : 3'h7);
  endtask

  initial
  begin
    repeat (20000) @(posedge CLK);
    fails++;
    stop_test();
  end

  initial
  begin
    {CORE_BANK_VALID, CORE_WRITE, CORE_LOCK, CORE_VECTOR, CORE_WAIT_OP} = 5'h00;
    {OPT_XCHG, SER_START, VECTOR_PULL_STRAP, CORE_ADDR, CORE_BANK} = 27'h0;
    {CORE_WDATA, ACC_WDATA, SER_OPERAND, SER_TXDATA, DATA_IN, reply} = 48'h0;
    {OPT_ENABLE_STRAP, IO_PORT_STRAP, BUS_FLOAT_CONTROL, BUS_FLOAT_CONTROL_ALT} = 4'hf;
    ready_ext = 1'b1;
    MCODE_STRAP = 2'h1;
    RST = 1'b1;
    // the link side syncs reset, so hold it over several link cycles
    repeat (5) @(negedge PHASE_TWO_CLOCK);
    @(negedge CLK);
    RST = 1'b0;
    repeat (3) @(negedge CLK);
    chk({USER_AUX_OUT, SER_SCLK, seln}, 8'h0f);
    CORE_LOCK = 1'b1;
    CORE_VECTOR = 1'b1;
    old = 8'h00;
    for (int m = 0; m < 4; m++)
    begin
      xchg({m[0], 5'h00, m[1:0]}, old);
      old = {m[0], 5'h00, m[1:0]};
      chk(MCODE_SEL, 8'(m));
      chk(USER_AUX_OUT, old[7]);
      chk(EXTENDED_MODE_N, m != 3);
      chk(HDR_A_MEMORY_LOCK_OUT_N, !m[0]);
      chk(HDR_A_VECTOR_PULL_OUT_N, 8'h01);
      chk({OPT_TWO_CYCLE_BCD, OPT_BCD_FLAGS_VALID, OPT_IRQ_CLD}, 8'h00);
    end
    CORE_BANK_VALID = 1'b1;
    CORE_BANK = 8'h05;
    repeat (4) @(negedge CLK);
    chk({HIGH_BANK_ACCESS_N, IO_PORT_EN}, 8'h00);
    chk(EXT_BANK_OUT, 8'h05);
    CORE_BANK = 8'h00;
    repeat (4) @(negedge CLK);
    chk({HIGH_BANK_ACCESS_N, IO_PORT_EN}, 8'h03);
    CORE_ADDR = 16'h1234;
    CORE_WDATA = 8'h5e;
    CORE_WRITE = 1'b1;
    DATA_IN = 8'hc3;
    ready_ext = 1'b0;
    repeat (4) @(negedge CLK);
    chk({CORE_STALL, HDR_A_RW, HDR_A_DATA_OE}, 8'h05);
    chk(HDR_B_ADDR[7:0], 8'h34);
    chk(CORE_RDATA, 8'hc3);
    BUS_FLOAT_CONTROL_ALT = 1'b0;
    #1;
    chk({HDR_A_ADDR_OE, HDR_B_ADDR_OE, HDR_A_DATA_OE, HDR_A_RW_OE}, 8'h00);
    @(negedge CLK);
    {BUS_FLOAT_CONTROL_ALT, ready_ext, CORE_WAIT_OP, VECTOR_PULL_STRAP} = 4'hf;
    repeat (4) @(negedge CLK);
    chk({READY_OE, READY_OUT, CORE_STALL, HDR_A_VECTOR_PULL_OUT_N}, 8'h0a);
    CORE_WAIT_OP = 1'b0;
    spi(8'h81, 8'ha5, 8'h3c);
    spi(8'h07, 8'h96, 8'hc1);
    OPT_ENABLE_STRAP = 1'b0;
    repeat (4) @(negedge CLK);
    chk({USER_AUX_OUT, OPT_TWO_CYCLE_BCD, OPT_BCD_FLAGS_VALID, OPT_IRQ_CLD, MCODE_SEL}, 8'h1d);
    stop_test();
  end
endmodule

bind cpco_top cpco_asserts #(.ADDR_W(ADDR_W)) i_cpco_asserts (.*);
